// ===== design/ppw_timer_pkg.sv
// constants shared by the pulse period/width timer channel
// assumes a single 100 MHz system clock and an apb register port
`default_nettype none
package ppw_timer_pkg;

    // -----------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // -----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_MODE = 12'h000;
    localparam logic [11:0] OFS_DATA = 12'h004;
    localparam logic [11:0] OFS_START = 12'h008;

    // -----------------------------------------------------------------
    // timer_mode_config field layout
    // -----------------------------------------------------------------
    localparam int MODE_W = 8;
    localparam int BIT_OP_LO = 0;
    localparam int BIT_MEAS_LO = 2;
    localparam int BIT_FREE = 4;
    localparam int BIT_OVF = 5;
    localparam int BIT_CLK_LO = 6;
    localparam logic [7:0] MODE_RST = 8'h00;

    localparam logic [1:0] OP_PULSE_MEAS = 2'h2;
    localparam logic [1:0] MEAS_FALL = 2'h0;
    localparam logic [1:0] MEAS_RISE = 2'h1;
    localparam logic [1:0] MEAS_BOTH = 2'h2;
    localparam logic [1:0] CLK_DIV1 = 2'h0;
    localparam logic [1:0] CLK_DIV8 = 2'h1;
    localparam logic [1:0] CLK_DIV32 = 2'h2;
    localparam logic [1:0] CLK_SUB32 = 2'h3;

    // -----------------------------------------------------------------
    // count start register and divider ratios
    // -----------------------------------------------------------------
    localparam int BIT_START = 0;
    localparam int BIT_VALID = 1;
    localparam int CNT_W = 16;
    localparam int DIV_W = 5;
    localparam logic [4:0] DIV8_LAST = 5'h07;
    localparam logic [4:0] DIV32_LAST = 5'h1f;
    localparam logic [4:0] SUB32_LAST = 5'h1f;

    typedef enum logic [1:0] {
        CAP_IDLE,
        CAP_FIRST,
        CAP_SECOND,
        CAP_RUN
    } cap_state_e;

endpackage
`default_nettype wire

// ===== design/pulse_edge_if.sv
// edge events of the measurement pulse, detector to timer core
// assumes both ends run on mclk
`timescale 1ns/10ps
`default_nettype none
interface pulse_edge_if;
    logic rise;
    logic fall;
    modport src (output rise, output fall);
    modport dst (input rise, input fall);
endinterface
`default_nettype wire

// ===== design/pulse_edge_detect.sv
// synchroniser and edge detector for the measurement pulse pin
// assumes the pin is asynchronous to mclk
`timescale 1ns/10ps
`default_nettype none
module pulse_edge_detect (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic pin,
    pulse_edge_if.src ev
);
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic level_q;
    logic level_d;
    logic rise_q;
    logic rise_d;
    logic fall_q;
    logic fall_d;

    // -----------------------------------------------------------------
    // a change counts only once stages two and three agree
    // -----------------------------------------------------------------
    always_comb begin
        sync_d = {sync_q[1:0], pin};
        level_d = level_q;
        rise_d = 1'b0;
        fall_d = 1'b0;
        if (sync_q[1] == sync_q[2] && sync_q[2] != level_q) begin // see [R12]
            level_d = sync_q[2];
            rise_d = sync_q[2];
            fall_d = ~sync_q[2];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sync_q <= 3'h0;
            level_q <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            sync_q <= sync_d;
            level_q <= level_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
        end
    end

    assign ev.rise = rise_q;
    assign ev.fall = fall_q;

    property p_edge_level;
        @(posedge mclk) disable iff (!resetn)
        rise_q |-> level_q && !fall_q;
    endproperty
    a_edge_level: assert property (p_edge_level) // see [R12]
        else $error("rise event without high settled level");

endmodule
`default_nettype wire

// ===== design/count_src_prescaler.sv
// count source selection: system clock taps and sub clock / 32
// assumes the sub clock pin is asynchronous and much slower than mclk
`timescale 1ns/10ps
`default_nettype none
module count_src_prescaler (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic sub_clk_pin,
    input wire logic [1:0] sel,
    output logic tick
);
    logic [4:0] div_q;
    logic [4:0] div_d;
    logic [4:0] sub_q;
    logic [4:0] sub_d;
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic sub_lvl_q;
    logic sub_lvl_d;
    logic tick_q;
    logic tick_d;
    logic sub_rise;

    // -----------------------------------------------------------------
    // free-running dividers, one selected tap becomes the tick
    // -----------------------------------------------------------------
    always_comb begin
        sync_d = {sync_q[1:0], sub_clk_pin};
        sub_lvl_d = sub_lvl_q;
        sub_rise = 1'b0;
        if (sync_q[1] == sync_q[2] && sync_q[2] != sub_lvl_q) begin
            sub_lvl_d = sync_q[2];
            sub_rise = sync_q[2];
        end
        div_d = div_q + 5'h01;
        sub_d = sub_rise ? sub_q + 5'h01 : sub_q;
        case (sel) // see [R14]
            ppw_timer_pkg::CLK_DIV1: tick_d = 1'b1;
            ppw_timer_pkg::CLK_DIV8:
                tick_d = div_q[2:0] == ppw_timer_pkg::DIV8_LAST[2:0];
            ppw_timer_pkg::CLK_DIV32:
                tick_d = div_q == ppw_timer_pkg::DIV32_LAST;
            default:
                tick_d = sub_rise && sub_q == ppw_timer_pkg::SUB32_LAST;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            div_q <= 5'h00;
            sub_q <= 5'h00;
            sync_q <= 3'h0;
            sub_lvl_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_d;
            sub_q <= sub_d;
            sync_q <= sync_d;
            sub_lvl_q <= sub_lvl_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

    property p_div8_gap;
        @(posedge mclk) disable iff (!resetn)
        (tick_q && sel == ppw_timer_pkg::CLK_DIV8 && $stable(sel))
            |=> (!tick_q || sel != ppw_timer_pkg::CLK_DIV8) [*7];
    endproperty
    a_div8_gap: assert property (p_div8_gap) // see [R14]
        else $error("div8 tick came early");

endmodule
`default_nettype wire

// ===== design/pulse_period_width_timer.sv
// timer channel in pulse period / pulse width measurement mode
// assumes an apb master on mclk, an async pulse pin and a sub clock pin
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// [R1] mode field value 10 selects pulse period or width measurement
// [R2] counter counts up; at effective edge copies into reload, restarts
// [R3] counting runs while the count start flag is 1, halts at 0
// [R4] edge select: 00 fall-fall, 01 rise-rise, 10 both edges, 11 forbidden
// [R5] request on every effective edge except the first after start
// [R6] overflow raises a request and sets the overflow flag together
// [R7] mode write after a count cycle with flag set clears the flag
// [R8] overflow flag is read-only; writes do not change it
// [R9] data register reads return the reload register, not the counter
// [R10] data read is undefined until the second edge is captured
// [R11] writes to the data register change neither counter nor reload
// [R12] the pin is the measurement pulse input, its edges sampled
// [R13] unassigned mode bit written 0, read value undefined
// [R14] count source field bits 7:6 selects div1, div8, div32, sub div32
// [R15] sixteen bit counter; overflow is the wrap from all ones
module pulse_period_width_timer #(
    parameter int CNT_W = ppw_timer_pkg::CNT_W
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic measure_pulse_pin,
    input wire logic sub_clock_pin,
    output logic irq_req
);
    pulse_edge_if ev ();

    logic tick;
    logic [1:0] op_q;
    logic [1:0] op_d;
    logic [1:0] meas_q;
    logic [1:0] meas_d;
    logic [1:0] clk_q;
    logic [1:0] clk_d;
    logic start_q;
    logic start_d;
    logic ovf_q;
    logic ovf_d;
    logic arm_q;
    logic arm_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] reload_q;
    logic [CNT_W-1:0] reload_d;
    ppw_timer_pkg::cap_state_e st_q;
    ppw_timer_pkg::cap_state_e st_d;
    logic irq_q;
    logic irq_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic ready_q;
    logic ready_d;
    logic err_q;
    logic err_d;
    logic setup;
    logic done;
    logic wr_mode;
    logic wr_data;
    logic wr_start;
    logic counting;
    logic meas_edge;
    logic ovf_evt;
    logic [7:0] mode_rd;

    // -----------------------------------------------------------------
    // sources: pin edges and the prescaled count tick
    // -----------------------------------------------------------------
    pulse_edge_detect u_edge (
        .mclk(mclk),
        .resetn(resetn),
        .pin(measure_pulse_pin), // see [R12]
        .ev(ev)
    );

    count_src_prescaler u_src (
        .mclk(mclk),
        .resetn(resetn),
        .sub_clk_pin(sub_clock_pin),
        .sel(clk_q),
        .tick(tick)
    );

    function automatic logic is_effective(input logic [1:0] sel,
                                          input logic rise,
                                          input logic fall);
        case (sel)
            ppw_timer_pkg::MEAS_FALL: is_effective = fall;
            ppw_timer_pkg::MEAS_RISE: is_effective = rise;
            ppw_timer_pkg::MEAS_BOTH: is_effective = rise | fall;
            // forbidden setting: no edge is effective
            default: is_effective = 1'b0;
        endcase
    endfunction

    // -----------------------------------------------------------------
    // apb decode: no wait state; read data leaves a flop loaded in the setup cycle
    // -----------------------------------------------------------------
    assign setup = psel && !penable;
    assign done = psel && penable && ready_q;
    assign wr_mode = done && pwrite && paddr == ppw_timer_pkg::OFS_MODE;
    assign wr_data = done && pwrite && paddr == ppw_timer_pkg::OFS_DATA;
    assign wr_start = done && pwrite && paddr == ppw_timer_pkg::OFS_START;

    always_comb begin
        mode_rd = ppw_timer_pkg::MODE_RST;
        mode_rd[ppw_timer_pkg::BIT_OP_LO +: 2] = op_q;
        mode_rd[ppw_timer_pkg::BIT_MEAS_LO +: 2] = meas_q;
        // unassigned bit is undefined to software; reads give 0
        mode_rd[ppw_timer_pkg::BIT_FREE] = 1'b0; // see [R13]
        mode_rd[ppw_timer_pkg::BIT_OVF] = ovf_q;
        mode_rd[ppw_timer_pkg::BIT_CLK_LO +: 2] = clk_q;
    end

    always_comb begin
        rdata_d = rdata_q;
        err_d = err_q;
        ready_d = 1'b0;
        if (setup) begin
            ready_d = 1'b1;
            rdata_d = 32'h0000_0000;
            err_d = 1'b0;
            if (paddr == ppw_timer_pkg::OFS_MODE) begin
                rdata_d[ppw_timer_pkg::MODE_W-1:0] = mode_rd;
            end else if (paddr == ppw_timer_pkg::OFS_DATA) begin
                rdata_d[CNT_W-1:0] = reload_q; // see [R9]
            end else if (paddr == ppw_timer_pkg::OFS_START) begin
                rdata_d[ppw_timer_pkg::BIT_START] = start_q;
                // valid only once the second edge has been captured
                rdata_d[ppw_timer_pkg::BIT_VALID] =
                    st_q == ppw_timer_pkg::CAP_RUN; // see [R10]
            end else begin
                err_d = 1'b1;
            end
        end
    end

    // -----------------------------------------------------------------
    // configuration and overflow flag
    // -----------------------------------------------------------------
    assign counting = start_q &&
                      op_q == ppw_timer_pkg::OP_PULSE_MEAS; // see [R1]
    assign meas_edge = counting && st_q != ppw_timer_pkg::CAP_IDLE &&
                       is_effective(meas_q, ev.rise, ev.fall); // see [R4]
    // a stale full count in the restart cycle is no overflow
    assign ovf_evt = counting && tick && !meas_edge &&
                     st_q != ppw_timer_pkg::CAP_IDLE &&
                     cnt_q == {CNT_W{1'b1}}; // see [R15]

    always_comb begin
        op_d = op_q;
        meas_d = meas_q;
        clk_d = clk_q;
        start_d = start_q;
        ovf_d = ovf_q;
        arm_d = arm_q;
        if (wr_mode) begin
            op_d = pwdata[ppw_timer_pkg::BIT_OP_LO +: 2];
            meas_d = pwdata[ppw_timer_pkg::BIT_MEAS_LO +: 2];
            clk_d = pwdata[ppw_timer_pkg::BIT_CLK_LO +: 2]; // see [R14]
        end
        if (wr_start) begin
            start_d = pwdata[ppw_timer_pkg::BIT_START]; // see [R3]
        end
        // the written overflow bit is never looked at, see [R8]
        if (ovf_q && start_q && tick) begin
            arm_d = 1'b1;
        end
        if (wr_mode && arm_q) begin // see [R7]
            ovf_d = 1'b0;
            arm_d = 1'b0;
        end
        // an overflow in the clearing cycle wins and re-arms later
        if (ovf_evt) begin // see [R6]
            ovf_d = 1'b1;
            arm_d = 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // counter, reload capture, edge sequencing and request
    // -----------------------------------------------------------------
    always_comb begin
        cnt_d = cnt_q;
        reload_d = reload_q;
        st_d = st_q;
        irq_d = 1'b0;
        // data register writes fall through untouched here
        if (!counting) begin // see [R11]
            st_d = ppw_timer_pkg::CAP_IDLE;
        end else if (st_q == ppw_timer_pkg::CAP_IDLE) begin
            // fresh start counts from zero
            st_d = ppw_timer_pkg::CAP_FIRST;
            cnt_d = '0;
        end else if (meas_edge) begin // see [R2]
            reload_d = cnt_q;
            cnt_d = '0;
            case (st_q)
                ppw_timer_pkg::CAP_FIRST: st_d = ppw_timer_pkg::CAP_SECOND;
                default: begin
                    st_d = ppw_timer_pkg::CAP_RUN;
                    irq_d = 1'b1; // see [R5]
                end
            endcase
        end else if (tick) begin
            cnt_d = cnt_q + 1'b1;
            irq_d = ovf_evt; // see [R6]
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            op_q <= 2'h0;
            meas_q <= 2'h0;
            clk_q <= 2'h0;
            start_q <= 1'b0;
            ovf_q <= 1'b0;
            arm_q <= 1'b0;
            cnt_q <= '0;
            reload_q <= '0;
            st_q <= ppw_timer_pkg::CAP_IDLE;
            irq_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            op_q <= op_d;
            meas_q <= meas_d;
            clk_q <= clk_d;
            start_q <= start_d;
            ovf_q <= ovf_d;
            arm_q <= arm_d;
            cnt_q <= cnt_d;
            reload_q <= reload_d;
            st_q <= st_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q <= err_d;
        end
    end

    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;
    assign irq_req = irq_q;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    property p_mode_gate;
        @(posedge mclk) disable iff (!resetn)
        (op_q != ppw_timer_pkg::OP_PULSE_MEAS) |=> $stable(cnt_q);
    endproperty
    a_mode_gate: assert property (p_mode_gate) // see [R1]
        else $error("counter moved outside measurement mode");

    property p_capture;
        @(posedge mclk) disable iff (!resetn)
        meas_edge |=> reload_q == $past(cnt_q) && cnt_q == '0;
    endproperty
    a_capture: assert property (p_capture) // see [R2]
        else $error("edge did not capture and restart");

    property p_stopped;
        @(posedge mclk) disable iff (!resetn)
        !start_q |=> $stable(cnt_q) && $stable(reload_q);
    endproperty
    a_stopped: assert property (p_stopped) // see [R3]
        else $error("counter moved while stopped");

    property p_fall_only;
        @(posedge mclk) disable iff (!resetn)
        (meas_q == ppw_timer_pkg::MEAS_FALL && !ev.fall) |=> $stable(reload_q);
    endproperty
    a_fall_only: assert property (p_fall_only) // see [R4]
        else $error("capture without falling edge");

    property p_first_quiet;
        @(posedge mclk) disable iff (!resetn)
        (meas_edge && st_q == ppw_timer_pkg::CAP_FIRST) |=> !irq_q;
    endproperty
    a_first_quiet: assert property (p_first_quiet) // see [R5]
        else $error("request on first edge");

    property p_later_irq;
        @(posedge mclk) disable iff (!resetn)
        (meas_edge && st_q != ppw_timer_pkg::CAP_FIRST) |=> irq_q;
    endproperty
    a_later_irq: assert property (p_later_irq) // see [R5]
        else $error("no request on measurement edge");

    property p_ovf_set;
        @(posedge mclk) disable iff (!resetn)
        ovf_evt |=> ovf_q && irq_q && cnt_q == '0;
    endproperty
    a_ovf_set: assert property (p_ovf_set) // see [R6]
        else $error("overflow not flagged with request");

    property p_ovf_clear;
        @(posedge mclk) disable iff (!resetn)
        (wr_mode && arm_q && !ovf_evt) |=> !ovf_q;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) // see [R7]
        else $error("armed mode write kept overflow flag");

    property p_ovf_ro;
        @(posedge mclk) disable iff (!resetn)
        (wr_mode && !arm_q && !ovf_evt) |=> ovf_q == $past(ovf_q);
    endproperty
    a_ovf_ro: assert property (p_ovf_ro) // see [R8]
        else $error("overflow flag changed by write");

    property p_read_reload;
        @(posedge mclk) disable iff (!resetn)
        (setup && paddr == ppw_timer_pkg::OFS_DATA)
            |=> pready && prdata[CNT_W-1:0] == $past(reload_q);
    endproperty
    a_read_reload: assert property (p_read_reload) // see [R9]
        else $error("data read not from reload register");

    property p_data_wr;
        @(posedge mclk) disable iff (!resetn)
        (wr_data && !meas_edge) |=> $stable(reload_q);
    endproperty
    a_data_wr: assert property (p_data_wr) // see [R11]
        else $error("data write altered reload");

endmodule
`default_nettype wire

// ===== bench/pulse_src.sv
// far side model: measurement pulse source and a free running sub clock
// assumes the bench holds run low whenever the pin must stand still
`timescale 1ns/10ps
`default_nettype none
module pulse_src (
    input wire logic mclk,
    input wire logic run,
    input wire logic [15:0] hi_len,
    input wire logic [15:0] lo_len,
    output logic pin,
    output logic sub_clk
);
    int cnt = 0;
    logic ph = 1'b0;

    initial begin
        pin = 1'b0;
        sub_clk = 1'b0;
    end

    // -----------------------------------------------------------------
    // sub clock rises every 4 mclk, so one sub/32 tick is 128 mclk
    // -----------------------------------------------------------------
    always @(posedge mclk) begin
        ph <= ~ph;
        if (ph) sub_clk <= ~sub_clk;
    end

    // -----------------------------------------------------------------
    // pin holds its level while stopped: no stray edges between runs
    // -----------------------------------------------------------------
    always @(posedge mclk) begin
        if (run) begin
            cnt = cnt + 1;
            if (cnt >= int'(pin ? hi_len : lo_len)) begin
                pin <= ~pin;
                cnt = 0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== bench/pulse_period_width_timer_bench.sv
// self-checking bench for the pulse period/width timer channel
// assumes the design files and the pulse_src model are compiled first
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, x, g) begin n_tests++; if ((g) !== (x)) begin errors++; \
    $display("Error %s exp %h got %h", n, x, g); end end
module pulse_period_width_timer_bench;
    // narrow counter keeps the overflow run short
    localparam int CW = 8;
    localparam logic [11:0] MO = ppw_timer_pkg::OFS_MODE;
    localparam logic [11:0] DA = ppw_timer_pkg::OFS_DATA;
    localparam logic [11:0] ST = ppw_timer_pkg::OFS_START;
    logic mclk, resetn, psel, penable, pwrite, pready, pslverr, irq_req;
    logic pin, sub_clk, run, e, w;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, m;
    logic [15:0] hi_len, lo_len;
    int errors = 0, n_tests = 0, n_irq = 0, n0, t, h, n;
    int div[4] = '{1, 8, 32, 128};

    pulse_period_width_timer #(.CNT_W(CW)) dut_u (.mclk(mclk),
        .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .measure_pulse_pin(pin),
        .sub_clock_pin(sub_clk), .irq_req(irq_req));
    pulse_src src_u (.mclk(mclk), .run(run), .hi_len(hi_len),
        .lo_len(lo_len), .pin(pin), .sub_clk(sub_clk));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) if (irq_req === 1'b1) n_irq <= n_irq + 1;

    // -----------------------------------------------------------------
    // apb master: request held until pready is sampled high
    // -----------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    // prescaler phase allows one tick either way
    function automatic logic near(input logic [31:0] g, input int x);
        return (g >= x - 1) && (g <= x + 1);
    endfunction

    task automatic stop_test();
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        #600000;
        errors++;
        $display("Error watchdog exp done got hang");
        stop_test();
    end

    initial begin
        resetn = 1'b0;
        {psel, penable, pwrite, run} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        {hi_len, lo_len} = 32'h0;
        void'($urandom(32'hfb567806));
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        rd(MO);
        `CHK("mode reset", 32'h0, r)
        wr(MO, 32'h20);
        rd(MO);
        `CHK("flag write", 1'b0, r[5])
        rd(12'h00c);
        `CHK("unmapped err", 1'b1, e)
        wr(ST, 32'h1);
        repeat (300) @(posedge mclk);
        rd(MO);
        `CHK("idle irq", 0, n_irq)
        `CHK("idle flag", 1'b0, r[5])
        wr(ST, 32'h0);
        wr(MO, 32'h02);
        n0 = n_irq;
        wr(ST, 32'h1);
        repeat (240) @(posedge mclk);
        `CHK("early wrap", 0, n_irq - n0)
        repeat (40) @(posedge mclk);
        `CHK("wrap irq", 1, n_irq - n0)
        rd(MO);
        `CHK("wrap flag", 1'b1, r[5])
        wr(MO, 32'h22);
        rd(MO);
        `CHK("flag clear", 1'b0, r[5])
        wr(ST, 32'h0);
        n0 = n_irq;
        repeat (600) @(posedge mclk);
        `CHK("halt irq", 0, n_irq - n0)
        // every source and every legal edge select at least once
        for (int i = 0; i < 6; i++) begin
            t = 2 * (8 + $urandom % 5);
            w = (i % 3 == 2);
            h = w ? t * div[i % 4] / 2 : t * div[i % 4] * 3 / 8;
            hi_len <= 16'(h);
            lo_len <= 16'(t * div[i % 4] - h);
            run <= 1'b1;
            wr(MO, {24'h0, 2'(i % 4), 2'b00, 2'(i % 3), 2'b10});
            n0 = n_irq;
            wr(ST, 32'h1);
            n = 0;
            // result only trusted once the second edge is in
            do begin
                rd(ST);
                n++;
            end while (r[1] !== 1'b1 && n < 4000);
            `CHK("valid", 1'b1, r[1])
            `CHK("first edge irq", 1, n_irq - n0)
            run <= 1'b0;
            repeat (20) @(posedge mclk);
            rd(DA);
            m = r;
            `CHK("measure", 1'b1, near(r, w ? t / 2 : t))
            wr(DA, $urandom);
            rd(DA);
            `CHK("data hold", m, r)
            wr(ST, 32'h0);
        end
        // forbidden edge select: a toggling pin must capture nothing
        hi_len <= 16'h0008;
        lo_len <= 16'h0008;
        run <= 1'b1;
        wr(MO, 32'h0e);
        n0 = n_irq;
        wr(ST, 32'h1);
        repeat (200) @(posedge mclk);
        `CHK("forbidden irq", 0, n_irq - n0)
        rd(DA);
        `CHK("forbidden hold", m, r)
        run <= 1'b0;
        wr(ST, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
